/* File: inc/flash_cmd_pkg.sv */
// Constants, opcodes, phase and command types of the serial flash command decoder.
// Assumes a 10 MHz system clock and a serial link clock at least eight times slower.
package flash_cmd_pkg;

  // System clock rate and derived cycle units
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1_000;

  // Busy times, as printed, in their own units
  localparam int SR_WRITE_MS = 40;
  localparam int SECTOR_ERASE_MS = 200;
  localparam int HALF_BLOCK_ERASE_MS = 1000;
  localparam int BLOCK_ERASE_MS = 2000;
  localparam int CHIP_ERASE_S = 80;
  localparam int BYTE_PROG_US = 30;
  localparam int PAGE_PROG_MS = 3;
  localparam int BYTE_PROG_CYC = BYTE_PROG_US * CYC_PER_US;

  // Opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_IDENT_READ = 8'h9f;
  localparam logic [7:0] OP_STATUS_BYTE_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_BYTE_WRITE = 8'h01;
  localparam logic [7:0] OP_PLAIN_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_QUAD_READ = 8'heb;
  localparam logic [7:0] OP_WORD_FOUR_LINE_READ = 8'he7;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_FOUR_LINE_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_DEEP_SLEEP_ENTRY = 8'hb9;
  localparam logic [7:0] OP_DEEP_SLEEP_RELEASE = 8'hab;
  localparam logic [7:0] OP_MAKER_DEVICE_ID = 8'h90;
  localparam logic [7:0] OP_SECURITY_BYTE_READ = 8'h2b;
  localparam logic [7:0] OP_SECURITY_BYTE_WRITE = 8'h2f;

  // Identification bytes; all values arbitrary
  localparam logic [7:0] IDENT_MAKER = 8'h5e;
  localparam logic [7:0] IDENT_TYPE = 8'h31;
  localparam logic [7:0] IDENT_CAPACITY = 8'h17;
  localparam logic [7:0] IDENT_DEVICE = 8'h42;
  localparam logic [1:0] IDENT_LAST = 2'h2;

  // Delivery and reset values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SECURITY_RESET = 8'h00;
  localparam logic [7:0] SECURITY_LOCK = 8'h02;

  // Phase lengths in bits received (clocks times lanes)
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_ADDR = 6'h18;
  localparam logic [5:0] LEN_FAST_DUMMY_SINGLE = 6'h08;
  localparam logic [5:0] LEN_FAST_DUMMY_QUAD = 6'h10;
  localparam logic [5:0] LEN_QUAD_READ_DUMMY = 6'h10;
  localparam logic [5:0] LEN_WORD_READ_DUMMY = 6'h08;
  localparam logic [5:0] STEP_SINGLE = 6'h01;
  localparam logic [5:0] STEP_QUAD = 6'h04;
  localparam logic [2:0] OUT_STEP_SINGLE = 3'h1;
  localparam logic [2:0] OUT_STEP_QUAD = 3'h4;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hf;

  // Transaction phase, one-hot
  typedef enum logic [7:0] {
    PH_IDLE = 8'h01,
    PH_OP = 8'h02,
    PH_ADDR = 8'h04,
    PH_MODE = 8'h08,
    PH_DUMMY = 8'h10,
    PH_DIN = 8'h20,
    PH_DOUT = 8'h40,
    PH_IGNORE = 8'h80
  } ph_e;

  // Decoded command
  typedef enum logic [4:0] {
    C_NONE, C_BAD, C_WL_SET, C_WL_CLR, C_IDENT, C_SR_READ, C_SR_WRITE, C_READ, C_FAST,
    C_QREAD, C_WREAD, C_PROG, C_QPROG, C_SECTOR, C_HALF_BLOCK, C_BLOCK, C_CHIP,
    C_SLEEP, C_SIG, C_MFR_ID, C_SEC_READ, C_SEC_WRITE
  } cmd_e;

endpackage

/* File: inc/byte_fifo_if.sv */
// Carrier between the command decoder and its response FIFO.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface byte_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] out_data;
  logic out_valid;
  logic out_ready;
  logic flush;
  modport store(input in_data, input in_valid, input out_ready, input flush,
                output in_ready, output out_data, output out_valid);
  modport user(output in_data, output in_valid, output out_ready, output flush,
               input in_ready, input out_data, input out_valid);
endinterface
`default_nettype wire

/* File: hw/byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic srst,
  byte_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  // Handshakes; full and empty come from the fill count
  assign port.in_ready = (fill != FULL);
  assign port.out_valid = (fill != '0);
  assign port.out_data = mem[rd_ptr];
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_ready && port.out_valid;

  // Pointers and fill; flush wins over traffic
  always_ff @(posedge mclk) begin
    if (srst || port.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) fill <= fill + 1'b1;
      else if (pop && !push) fill <= fill - 1'b1;
    end
  end

  // Storage needs no reset, only valid entries are read
  always_ff @(posedge mclk) begin
    if (push) mem[wr_ptr] <= port.in_data;
  end
endmodule
`default_nettype wire

/* File: hw/flash_cmd_decoder.sv */
// Command decoding front end of a serial NOR flash, seen from inside the device.
// Assumes sclk runs at most at mclk/8 and that the array itself is not modelled.
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter int unsigned SR_WRITE_CYC = SR_WRITE_MS * CYC_PER_MS,
  parameter int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CYC_PER_MS,
  parameter int unsigned HALF_BLOCK_ERASE_CYC = HALF_BLOCK_ERASE_MS * CYC_PER_MS,
  parameter int unsigned BLOCK_ERASE_CYC = BLOCK_ERASE_MS * CYC_PER_MS,
  parameter int unsigned CHIP_ERASE_CYC = CHIP_ERASE_S * CLK_HZ,
  parameter int unsigned PAGE_PROG_CYC = PAGE_PROG_MS * CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic quad_instruction_mode,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic busy,
  output logic deep_sleep
);

  // Opcode table with per-mode validity
  function automatic cmd_e decode_op(input logic [7:0] op, input logic quad);
    case (op)
      OP_WRITE_LATCH_SET: decode_op = C_WL_SET;
      OP_WRITE_LATCH_CLEAR: decode_op = C_WL_CLR;
      OP_IDENT_READ: decode_op = quad ? C_BAD : C_IDENT;
      OP_STATUS_BYTE_READ: decode_op = C_SR_READ;
      OP_STATUS_BYTE_WRITE: decode_op = C_SR_WRITE;
      OP_PLAIN_READ: decode_op = quad ? C_BAD : C_READ;
      OP_FAST_READ: decode_op = C_FAST;
      OP_QUAD_READ: decode_op = C_QREAD;
      OP_WORD_FOUR_LINE_READ: decode_op = quad ? C_BAD : C_WREAD;
      OP_PAGE_PROGRAM: decode_op = C_PROG;
      OP_FOUR_LINE_PAGE_PROGRAM: decode_op = quad ? C_BAD : C_QPROG;
      OP_SECTOR_ERASE: decode_op = C_SECTOR;
      OP_HALF_BLOCK_ERASE: decode_op = C_HALF_BLOCK;
      OP_BLOCK_ERASE: decode_op = C_BLOCK;
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: decode_op = C_CHIP;
      OP_DEEP_SLEEP_ENTRY: decode_op = C_SLEEP;
      OP_DEEP_SLEEP_RELEASE: decode_op = C_SIG;
      OP_MAKER_DEVICE_ID: decode_op = C_MFR_ID;
      OP_SECURITY_BYTE_READ: decode_op = C_SEC_READ;
      OP_SECURITY_BYTE_WRITE: decode_op = C_SEC_WRITE;
      default: decode_op = C_BAD;
    endcase
  endfunction

  // Every nibble bit must differ from its partner to stay in continuation
  function automatic logic toggling(input logic [7:0] ind);
    toggling = &(ind[7:4] ^ ind[3:0]);
  endfunction

  // Commands that need the write latch
  function automatic logic is_write(input cmd_e c);
    is_write = c inside {C_SR_WRITE, C_PROG, C_QPROG, C_SECTOR, C_HALF_BLOCK, C_BLOCK,
                         C_CHIP, C_SEC_WRITE};
  endfunction

  // Busy length per write command
  function automatic logic [31:0] busy_time(input cmd_e c, input logic [8:0] nbytes);
    logic [31:0] prog;
    prog = 32'(nbytes) * 32'(BYTE_PROG_CYC);
    case (c)
      C_SR_WRITE: busy_time = 32'(SR_WRITE_CYC);
      C_SECTOR: busy_time = 32'(SECTOR_ERASE_CYC);
      C_HALF_BLOCK: busy_time = 32'(HALF_BLOCK_ERASE_CYC);
      C_BLOCK: busy_time = 32'(BLOCK_ERASE_CYC);
      C_CHIP: busy_time = 32'(CHIP_ERASE_CYC);
      default: busy_time = (prog > 32'(PAGE_PROG_CYC)) ? 32'(PAGE_PROG_CYC) : prog;
    endcase
  endfunction

  logic [1:0] sclk_s;
  logic sclk_d;
  logic [1:0] cs_s;
  logic cs_act_d;
  logic [3:0] io_s0;
  logic [3:0] io_s1;
  logic cs_active;
  logic cs_start;
  logic cs_end;
  logic rise;
  logic fall;

  ph_e phase;
  cmd_e cmd;
  cmd_e op_cmd;
  logic lanes4;
  logic [5:0] cnt;
  logic [5:0] len;
  logic [5:0] step;
  logic [5:0] cnt_nxt;
  logic last;
  logic in_phase;
  logic [23:0] sh;
  logic [23:0] sh_nxt;
  logic addr_lsb;
  logic [8:0] byte_cnt;
  logic cmd_ok;
  logic [7:0] sr_data;
  logic cont;

  logic [5:0] status_hi;
  logic wel;
  logic [31:0] busy_cnt;
  logic [7:0] sec;
  logic [7:0] status_byte;

  logic [1:0] idx;
  logic [7:0] gen_byte;
  logic [7:0] oshift;
  logic [7:0] obyte;
  logic [2:0] ocnt;

  byte_fifo_if #(.WIDTH(BYTE_BITS)) fq ();

  byte_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .port(fq.store)
  );

  // Pins come from another domain: two flops, then a third for edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_s <= 2'h0;
      sclk_d <= 1'b0;
      cs_s <= 2'h3;
      cs_act_d <= 1'b0;
      io_s0 <= 4'h0;
      io_s1 <= 4'h0;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      sclk_d <= sclk_s[1];
      cs_s <= {cs_s[0], cs_n};
      cs_act_d <= cs_active;
      io_s0 <= io_in;
      io_s1 <= io_s0;
    end
  end

  assign cs_active = ~cs_s[1];
  assign cs_start = cs_active & ~cs_act_d;
  assign cs_end = ~cs_active & cs_act_d;
  assign rise = cs_active & sclk_s[1] & ~sclk_d;
  assign fall = cs_active & ~sclk_s[1] & sclk_d;

  // Input shifting: one lane on io[0], or four lanes
  assign step = lanes4 ? STEP_QUAD : STEP_SINGLE;
  assign cnt_nxt = cnt + step;
  assign last = (cnt_nxt == len);
  assign sh_nxt = lanes4 ? {sh[19:0], io_s1} : {sh[22:0], io_s1[0]};
  assign in_phase = phase inside {PH_OP, PH_ADDR, PH_MODE, PH_DUMMY, PH_DIN};
  assign op_cmd = decode_op(sh_nxt[7:0], quad_instruction_mode);

  // Transaction sequencer, advanced on sampled rising edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase <= PH_IDLE;
      cmd <= C_NONE;
      lanes4 <= 1'b0;
      cnt <= '0;
      len <= LEN_BYTE;
      sh <= '0;
      addr_lsb <= 1'b0;
      byte_cnt <= '0;
      cmd_ok <= 1'b0;
      sr_data <= STATUS_RESET;
      cont <= 1'b0;
    end else if (cs_start) begin
      cnt <= '0;
      cmd_ok <= 1'b0;
      byte_cnt <= '0;
      if (cont) begin
        cmd <= C_QREAD;
        phase <= PH_ADDR;
        lanes4 <= 1'b1;
        len <= LEN_ADDR;
      end else begin
        cmd <= C_NONE;
        phase <= PH_OP;
        lanes4 <= quad_instruction_mode;
        len <= LEN_BYTE;
      end
    end else if (cs_end) begin
      phase <= PH_IDLE;
    end else if (rise && in_phase) begin
      sh <= sh_nxt;
      cnt <= last ? '0 : cnt_nxt;
      if (last) begin
        unique case (phase)
          PH_OP: begin
            cmd <= op_cmd;
            if (op_cmd == C_BAD || (busy && op_cmd != C_SR_READ)
                || (deep_sleep && op_cmd != C_SIG)) begin
              phase <= PH_IGNORE;
            end else begin
              case (op_cmd)
                C_WL_SET, C_WL_CLR, C_CHIP, C_SLEEP, C_SEC_WRITE: begin
                  cmd_ok <= 1'b1;
                  phase <= PH_IGNORE;
                end
                C_SR_READ, C_IDENT, C_SEC_READ: phase <= PH_DOUT;
                C_SR_WRITE: begin
                  phase <= PH_DIN;
                  len <= LEN_BYTE;
                end
                default: begin
                  phase <= PH_ADDR;
                  len <= LEN_ADDR;
                  lanes4 <= quad_instruction_mode
                            | (op_cmd inside {C_QREAD, C_WREAD, C_QPROG});
                end
              endcase
            end
          end
          PH_ADDR: begin
            addr_lsb <= sh_nxt[0];
            case (cmd)
              C_READ, C_MFR_ID, C_SIG: phase <= PH_DOUT;
              C_FAST: begin
                phase <= PH_DUMMY;
                len <= lanes4 ? LEN_FAST_DUMMY_QUAD : LEN_FAST_DUMMY_SINGLE;
              end
              C_QREAD, C_WREAD: begin
                phase <= PH_MODE;
                len <= LEN_BYTE;
              end
              C_PROG, C_QPROG: begin
                phase <= PH_DIN;
                len <= LEN_BYTE;
              end
              default: begin
                cmd_ok <= 1'b1;
                phase <= PH_IGNORE;
              end
            endcase
          end
          PH_MODE: begin
            cont <= toggling(sh_nxt[7:0]);
            phase <= PH_DUMMY;
            // Host drives these clocks, so sampled values are simply dropped
            len <= (cmd == C_QREAD) ? LEN_QUAD_READ_DUMMY : LEN_WORD_READ_DUMMY;
          end
          PH_DUMMY: phase <= PH_DOUT;
          PH_DIN: begin
            cmd_ok <= 1'b1;
            if (cmd == C_SR_WRITE) begin
              sr_data <= sh_nxt[7:0];
              phase <= PH_IGNORE;
            end else if (byte_cnt != PAGE_BYTES) begin
              byte_cnt <= byte_cnt + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Write latch, busy timer, sleep and stored bytes; act on deselect
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_hi <= STATUS_RESET[7:2];
      wel <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= '0;
      deep_sleep <= 1'b0;
      sec <= SECURITY_RESET;
    end else begin
      if (busy_cnt != '0) begin
        busy_cnt <= busy_cnt - 1'b1;
        if (busy_cnt == 32'h1) begin
          busy <= 1'b0;
          wel <= 1'b0;
        end
      end
      if (cs_end && cmd == C_SIG) deep_sleep <= 1'b0;
      if (cs_end && cmd_ok) begin
        case (cmd)
          C_WL_SET: wel <= 1'b1;
          C_WL_CLR: wel <= 1'b0;
          C_SLEEP: deep_sleep <= 1'b1;
          C_SEC_WRITE: begin
            if (wel) begin
              sec <= sec | SECURITY_LOCK;
              wel <= 1'b0;
            end
          end
          default: begin
            if (wel && is_write(cmd)) begin
              busy <= 1'b1;
              busy_cnt <= busy_time(cmd, byte_cnt);
              if (cmd == C_SR_WRITE) status_hi <= sr_data[7:2];
            end
          end
        endcase
      end
    end
  end

  assign status_byte = {status_hi, wel, busy};

  // Response bytes; array is not modelled and reads as erased
  always_comb begin
    case (cmd)
      C_SR_READ: gen_byte = status_byte;
      C_SEC_READ: gen_byte = sec;
      C_IDENT: gen_byte = (idx == 2'h0) ? IDENT_MAKER
                        : (idx == 2'h1) ? IDENT_TYPE : IDENT_CAPACITY;
      C_MFR_ID: gen_byte = (idx[0] ^ addr_lsb) ? IDENT_DEVICE : IDENT_MAKER;
      C_SIG: gen_byte = IDENT_DEVICE;
      default: gen_byte = ERASED_BYTE;
    endcase
  end

  // Producer stalls on a full FIFO; queued status may lag by a few bytes
  assign fq.in_valid = (phase == PH_DUMMY) || (phase == PH_DOUT);
  assign fq.in_data = gen_byte;
  assign fq.flush = cs_start | cs_end;
  assign fq.out_ready = fall && (phase == PH_DOUT) && (ocnt == 3'h0);

  always_ff @(posedge mclk) begin
    if (srst || cs_start) begin
      idx <= 2'h0;
    end else if (fq.in_valid && fq.in_ready) begin
      idx <= (cmd == C_IDENT && idx == IDENT_LAST) ? 2'h0 : idx + 1'b1;
    end
  end

  // Output shifter: new byte on a byte boundary, underrun sends erased
  assign obyte = (ocnt != 3'h0) ? oshift : (fq.out_valid ? fq.out_data : ERASED_BYTE);

  always_ff @(posedge mclk) begin
    if (srst) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      oshift <= '0;
      ocnt <= 3'h0;
    end else if (phase != PH_DOUT) begin
      io_oe <= 4'h0;
      ocnt <= 3'h0;
    end else if (fall) begin
      if (lanes4) begin
        io_oe <= OE_QUAD;
        io_out <= obyte[7:4];
        oshift <= {obyte[3:0], 4'h0};
        ocnt <= ocnt + OUT_STEP_QUAD;
      end else begin
        io_oe <= OE_SINGLE;
        io_out <= {2'h0, obyte[7], 1'b0}; // Single-line data leaves on io[1]
        oshift <= {obyte[6:0], 1'b0};
        ocnt <= ocnt + OUT_STEP_SINGLE;
      end
    end
  end

endmodule
`default_nettype wire

/* File: bench/flash_cmd_asserts.sv */
// Port-level checks on the flash command decoder.
// Sees only the top ports; bound to the decoder at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic quad_instruction_mode,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic busy,
  input wire logic deep_sleep
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Everything quiet on the first edge after reset
  a_reset_quiet: assert property ($fell(srst) |-> io_oe == 4'h0 && !busy && !deep_sleep)
    else $error("outputs not quiet after reset");
  // Only the single-line and four-line enable patterns exist
  a_oe_legal: assert property (io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hf)
    else $error("illegal output enable pattern");
  // Quad-instruction mode answers on all four lines
  a_quad_oe_wide: assert property (quad_instruction_mode && io_oe != 4'h0 |-> io_oe == 4'hf)
    else $error("narrow output in quad instruction mode");
  // Pins released once deselect has been seen
  a_idle_release: assert property (cs_n [*7] |-> io_oe == 4'h0)
    else $error("pins driven while deselected");
  // No answer can come before a whole opcode is in
  a_start_quiet: assert property ($fell(cs_n) |-> ##4 (io_oe == 4'h0) [*8])
    else $error("output during opcode phase");
  // Commands act only at deselect
  a_busy_at_deselect: assert property ($rose(busy) |-> cs_n)
    else $error("busy rose inside a frame");
  // Even shortened cycles last well beyond a few clocks
  a_busy_holds: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped too soon");
  // Sleep entry acts at deselect, and sleep blocks writes
  a_sleep_at_deselect: assert property ($rose(deep_sleep) |-> cs_n && !busy)
    else $error("sleep entered inside a frame");
  a_no_write_asleep: assert property ($rose(busy) |-> !deep_sleep)
    else $error("write started while asleep");
endmodule
bind flash_cmd_decoder flash_cmd_asserts u_flash_cmd_asserts (.mclk(mclk), .srst(srst),
  .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .quad_instruction_mode(quad_instruction_mode),
  .io_out(io_out), .io_oe(io_oe), .busy(busy), .deep_sleep(deep_sleep));
`default_nettype wire

/* File: bench/spi_host_model.sv */
// Host serial controller: frames, mode 0 serial clock, one or four lines.
// Assumes the caller enters each task right after a rising mclk edge.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model #(
  parameter int WRITE_INHIBIT_CYC = 20
) (
  input wire logic mclk,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output var logic sclk,
  output var logic cs_n,
  output wire logic [3:0] io_in
);
  logic [3:0] host_d = 4'h0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Wire level: the device wins where it drives
  assign io_in = (io_oe & io_out) | (~io_oe & host_d);
  // Released lines toggle between frames so a stale value never matches
  always @(posedge mclk) if (cs_n) host_d <= ~host_d;
  // Power-up wait before any write, shortened
  task automatic inhibit_wait();
    repeat (WRITE_INHIBIT_CYC) @(posedge mclk);
  endtask
  // One serial clock; lines stay driven through dummy clocks too
  task automatic pulse(input logic [3:0] d, output logic [3:0] q);
    sclk <= 1'b0;
    host_d <= d;
    repeat (4) @(posedge mclk);
    sclk <= 1'b1;
    repeat (4) @(posedge mclk);
    q = io_in;
  endtask
  // One byte, msb first; two nibbles on four lines
  task automatic xbyte(input logic [7:0] b, input bit quad, output logic [7:0] r);
    logic [3:0] q;
    if (quad) begin
      pulse(b[7:4], q);
      r[7:4] = q;
      pulse(b[3:0], q);
      r[3:0] = q;
    end else for (int i = 7; i >= 0; i--) begin
      pulse({{3{i[0]}}, b[i]}, q); // Spare lines never idle at 00 or ff
      r[i] = q[1];
    end
  endtask
  task automatic open_frame();
    cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic close_frame();
    sclk <= 1'b0;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the flash command decoder with a host model.
// Assumes shortened busy counts; expectations derive from them.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import flash_cmd_pkg::*;
  localparam int SECT = 100, HALF = 150, BLK = 250, CHIP = 300, SRW = 200, PROG = 400;
  logic mclk = 1'b0, srst = 1'b1, qmode = 1'b0, busy_q = 1'b0;
  wire logic sclk, cs_n, busy, deep_sleep;
  wire logic [3:0] io_in, io_out, io_oe;
  int errors = 0, compares = 0, cycles = 0, run = 0;
  logic [3:0] last_oe;
  logic [15:0] r;
  flash_cmd_decoder #(.SR_WRITE_CYC(SRW), .SECTOR_ERASE_CYC(SECT), .HALF_BLOCK_ERASE_CYC(HALF),
    .BLOCK_ERASE_CYC(BLK), .CHIP_ERASE_CYC(CHIP), .PAGE_PROG_CYC(PROG)) u_flash_cmd_decoder (
    .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .quad_instruction_mode(qmode), .io_out(io_out), .io_oe(io_oe), .busy(busy),
    .deep_sleep(deep_sleep));
  spi_host_model u_spi_host_model (.mclk(mclk), .io_out(io_out), .io_oe(io_oe), .sclk(sclk),
    .cs_n(cs_n), .io_in(io_in));
  initial forever #50 mclk = ~mclk;
  // Length of the latest busy run, held after it ends
  always @(posedge mclk) begin
    busy_q <= busy;
    if (busy === 1'b1) run <= (busy_q === 1'b1) ? run + 1 : 1;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One frame: opcode unless skipped, na following bytes, then two bytes read if rdb
  task automatic rd(input bit skip, input logic [7:0] op, input int na, input logic [47:0] tail,
                    input bit rdb);
    logic [7:0] b;
    bit w;
    w = qmode || (op inside {OP_QUAD_READ, OP_WORD_FOUR_LINE_READ, OP_FOUR_LINE_PAGE_PROGRAM});
    u_spi_host_model.open_frame();
    if (!skip) u_spi_host_model.xbyte(op, qmode, b);
    for (int k = 0; k < na; k++) u_spi_host_model.xbyte(tail[47 - 8 * k -: 8], w, b);
    if (rdb) u_spi_host_model.xbyte(8'h5a, w, r[15:8]);
    if (rdb) u_spi_host_model.xbyte(8'h5a, w, r[7:0]);
    last_oe = io_oe;
    u_spi_host_model.close_frame();
  endtask
  task automatic cmd(input logic [7:0] op);
    rd(1'b0, op, 0, 48'h0, 1'b0);
  endtask
  // Waits out busy, bounded, then checks the run length
  task automatic busy_run(input int len);
    check("busy start", 16'h1, {15'h0, busy});
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge mclk);
    check("busy cycles", 16'h1, 16'((run >= len - 2) && (run <= len + 2)));
  endtask
  task automatic s_delivery();
    rd(1'b0, OP_STATUS_BYTE_READ, 0, 48'h0, 1'b1);
    check("status at delivery", {2{STATUS_RESET}}, r);
    rd(1'b0, OP_PLAIN_READ, 3, 48'h0, 1'b1);
    check("plain read", {2{ERASED_BYTE}}, r);
    rd(1'b0, OP_FAST_READ, 4, 48'h0, 1'b1);
    check("fast read", {2{ERASED_BYTE}}, r);
    check("single oe", 16'h2, {12'h0, last_oe});
  endtask
  task automatic s_latch();
    for (int q = 0; q < 2; q++) begin
      qmode <= q[0];
      @(posedge mclk);
      cmd(OP_WRITE_LATCH_SET);
      rd(1'b0, OP_STATUS_BYTE_READ, 0, 48'h0, 1'b1);
      check("latch set", 16'h0202, r);
      cmd(OP_WRITE_LATCH_CLEAR);
      rd(1'b0, OP_STATUS_BYTE_READ, 0, 48'h0, 1'b1);
      check("latch clear", 16'h0000, r);
    end
  endtask
  task automatic s_ident();
    logic [7:0] bad [3] = '{OP_IDENT_READ, OP_PLAIN_READ, OP_WORD_FOUR_LINE_READ};
    rd(1'b0, OP_FAST_READ, 5, 48'h0, 1'b1);
    check("quad fast read", {ERASED_BYTE, 8'h0f}, {r[15:8], 4'h0, last_oe});
    foreach (bad[k]) begin
      rd(1'b0, bad[k], 3, 48'h0, 1'b1);
      check("refused oe", 16'h0, {12'h0, last_oe});
    end
    qmode <= 1'b0;
    @(posedge mclk);
    rd(1'b0, OP_IDENT_READ, 0, 48'h0, 1'b1);
    check("ident", {IDENT_MAKER, IDENT_TYPE}, r);
    rd(1'b0, OP_MAKER_DEVICE_ID, 3, 48'h0, 1'b1);
    check("maker first", {IDENT_MAKER, IDENT_DEVICE}, r);
    rd(1'b0, OP_MAKER_DEVICE_ID, 3, {24'h000001, 24'h0}, 1'b1);
    check("device first", {IDENT_DEVICE, IDENT_MAKER}, r);
    rd(1'b0, OP_WORD_FOUR_LINE_READ, 5, 48'h0, 1'b1);
    check("word read", {ERASED_BYTE, 8'h0f}, {r[15:8], 4'h0, last_oe});
  endtask
  task automatic s_erase();
    logic [7:0] op [5] = '{OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE,
                           OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    int len [5] = '{SECT, HALF, BLK, CHIP, CHIP};
    rd(1'b0, OP_SECTOR_ERASE, 3, 48'h0, 1'b0);
    check("erase without latch", 16'h0, {15'h0, busy});
    foreach (op[k]) begin
      cmd(OP_WRITE_LATCH_SET);
      rd(1'b0, op[k], (k < 3) ? 3 : 0, 48'h0, 1'b0);
      busy_run(len[k]);
      rd(1'b0, OP_STATUS_BYTE_READ, 0, 48'h0, 1'b1);
      check("latch after erase", 16'h0, r);
    end
    cmd(OP_WRITE_LATCH_SET);
    rd(1'b0, OP_FOUR_LINE_PAGE_PROGRAM, 4, 48'h0, 1'b0);
    busy_run(BYTE_PROG_CYC);
  endtask
  task automatic s_write();
    qmode <= 1'b1;
    @(posedge mclk);
    cmd(OP_WRITE_LATCH_SET);
    rd(1'b0, OP_FOUR_LINE_PAGE_PROGRAM, 4, 48'h0, 1'b0);
    check("refused program", 16'h0, {15'h0, busy});
    rd(1'b0, OP_PAGE_PROGRAM, 4, 48'h0000005a0000, 1'b0);
    busy_run(BYTE_PROG_CYC);
    cmd(OP_WRITE_LATCH_SET);
    cmd(OP_SECURITY_BYTE_WRITE);
    rd(1'b0, OP_SECURITY_BYTE_READ, 0, 48'h0, 1'b1);
    check("security byte", {8'h0, SECURITY_LOCK}, {8'h0, r[15:8]});
    cmd(OP_WRITE_LATCH_SET);
    rd(1'b0, OP_STATUS_BYTE_WRITE, 1, {8'h3c, 40'h0}, 1'b0);
    busy_run(SRW);
    rd(1'b0, OP_STATUS_BYTE_READ, 0, 48'h0, 1'b1);
    check("status written", 16'h3c3c, r);
  endtask
  task automatic s_sleep();
    cmd(OP_DEEP_SLEEP_ENTRY);
    check("asleep", 16'h1, {15'h0, deep_sleep});
    rd(1'b0, OP_STATUS_BYTE_READ, 0, 48'h0, 1'b1);
    check("asleep oe", 16'h0, {12'h0, last_oe});
    rd(1'b0, OP_DEEP_SLEEP_RELEASE, 3, 48'h0, 1'b1);
    check("signature", {2{IDENT_DEVICE}}, r);
    check("awake", 16'h0, {15'h0, deep_sleep});
  endtask
  // First address byte is the status opcode: it only reads FF on four lines if continued
  task automatic s_cont();
    rd(1'b0, OP_QUAD_READ, 6, 48'h050000a50000, 1'b1);
    check("quad read", {2{ERASED_BYTE}}, r);
    rd(1'b1, 8'h00, 6, 48'h050000ff0000, 1'b1);
    check("continued read", {ERASED_BYTE, 8'h0f}, {r[15:8], 4'h0, last_oe});
    qmode <= 1'b0;
    @(posedge mclk);
    rd(1'b0, OP_STATUS_BYTE_READ, 0, 48'h0, 1'b1);
    check("continuation left", 16'h2, {12'h0, last_oe});
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    u_spi_host_model.inhibit_wait();
    s_delivery();
    s_latch();
    s_ident();
    s_erase();
    s_sleep();
    s_write();
    qmode <= 1'b1;
    @(posedge mclk);
    s_cont();
    wrap_up();
  end
endmodule
`default_nettype wire
